// ---- pmic_i2c_target.sv ----
// Two-wire bus target of the power controller, with its write buffer.
// Assumes the register bank sits on sys_clk, answers reads combinationally
// and drains writes through a valid/ready port. Bus pins are asynchronous.
`include "pmic_i2c_defs.svh"

////////////////////////////////////////////////////////////////////////////
module wr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; only valid entries are ever read out
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : wr_fifo

////////////////////////////////////////////////////////////////////////////
module pmic_i2c_target
    import pmic_i2c_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic otp_done,
    input wire logic [6:0] main_addr_otp,
    output logic osc_req,
    output logic wr_valid,
    input wire logic wr_ready,
    output wr_req_t wr_req,
    output logic rd_space,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    ////////////////////////////////////////////////////////////////////////
    // Pin sampling: three stages, level moves when stages two and three agree
    logic [1:0] sy1_q;
    logic [1:0] sy2_q;
    logic [1:0] sy3_q;
    logic [1:0] filt_q;
    logic [1:0] prev_q;
    wire [1:0] pins = {scl_i, sda_i};

    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                sy1_q[i] <= 1'b1;
                sy2_q[i] <= 1'b1;
                sy3_q[i] <= 1'b1;
                filt_q[i] <= 1'b1;
                prev_q[i] <= 1'b1;
            end else begin
                sy1_q[i] <= pins[i];
                sy2_q[i] <= sy1_q[i];
                sy3_q[i] <= sy2_q[i];
                filt_q[i] <= (sy2_q[i] == sy3_q[i]) ? sy3_q[i] : filt_q[i];
                prev_q[i] <= filt_q[i];
            end
        end
    end

    wire scl = filt_q[1];
    wire sda = filt_q[0];
    wire scl_rise = scl && !prev_q[1];
    wire scl_fall = !scl && prev_q[1];
    wire start_ev = scl && prev_q[1] && !sda && prev_q[0];
    wire stop_ev = scl && prev_q[1] && sda && !prev_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Target state
    tgt_state_t st_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic [6:0] main_q;
    logic ready_q;
    logic rw_q;
    logic space_q;
    logic ack_go_q;
    logic ack_ph_q;
    logic ptr_ph_q;
    logic mack_q;
    logic oe_q;

    wire [7:0] rx_byte = {sh_q[6:0], sda};
    wire byte_done = scl_rise && (cnt_q == `I2C_LAST_BIT);
    wire is_gcall = rx_byte[7:1] == `I2C_GCALL_ADDR;
    wire is_tenbit = rx_byte[7:3] == `I2C_TENBIT_PFX;
    wire hit_main = rx_byte[7:1] == main_q;
    wire hit_prog = rx_byte[7:1] == `I2C_PROG_ADDR;
    wire addr_hit = (hit_main || hit_prog) && !is_gcall && !is_tenbit;
    wire data_byte = (st_q == ST_WBYTE) && byte_done && !ptr_ph_q;

    ////////////////////////////////////////////////////////////////////////
    // Write buffer toward the register bank
    logic fifo_in_ready;
    wr_req_t fifo_in;
    assign fifo_in = '{prog_space: space_q, addr: ptr_q, data: rx_byte};

    wr_fifo #(
        .WIDTH($bits(wr_req_t)),
        .DEPTH(`WFIFO_DEPTH)
    ) u_wfifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(data_byte),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_req)
    );

    ////////////////////////////////////////////////////////////////////////
    // Store-loaded settings and readiness
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            main_q <= `I2C_MAIN_ADDR_RST;
            ready_q <= 1'b0;
        end else if (otp_done && !ready_q) begin
            main_q <= main_addr_otp;
            ready_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus sequencer; bits sampled on clock rise, driven on clock fall
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            ptr_q <= '0;
            rw_q <= 1'b0;
            space_q <= 1'b0;
            ack_go_q <= 1'b0;
            ack_ph_q <= 1'b0;
            ptr_ph_q <= 1'b0;
            mack_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (stop_ev) begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
        end else if (start_ev && ready_q) begin
            // Repeated start keeps the pointer for the read phase
            st_q <= ST_ADDR;
            cnt_q <= '0;
            oe_q <= 1'b0;
            ack_ph_q <= 1'b0;
        end else begin
            if (scl_rise) begin
                cnt_q <= cnt_q + 3'h1;
                sh_q <= rx_byte;
            end
            unique case (st_q)
                ST_IDLE, ST_SKIP: begin
                    oe_q <= 1'b0;
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        rw_q <= sda;
                        space_q <= hit_prog && !hit_main;
                        ptr_ph_q <= !sda;
                        ack_go_q <= addr_hit;
                        st_q <= addr_hit ? ST_ACK : ST_SKIP;
                    end
                end
                ST_WBYTE: begin
                    if (byte_done) begin
                        st_q <= ST_ACK;
                        if (ptr_ph_q) begin
                            ptr_q <= rx_byte;
                            ptr_ph_q <= 1'b0;
                            ack_go_q <= 1'b1;
                        end else begin
                            // Full buffer refuses the byte with a NACK
                            ack_go_q <= fifo_in_ready;
                            if (fifo_in_ready) begin
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall && !ack_ph_q) begin
                        oe_q <= ack_go_q;
                        ack_ph_q <= 1'b1;
                    end else if (scl_fall) begin
                        ack_ph_q <= 1'b0;
                        cnt_q <= '0;
                        if (!ack_go_q) begin
                            oe_q <= 1'b0;
                            st_q <= ST_SKIP;
                        end else if (rw_q) begin
                            sh_q <= rd_data;
                            oe_q <= !rd_data[7];
                            ptr_q <= ptr_q + 8'h01;
                            st_q <= ST_RBYTE;
                        end else begin
                            oe_q <= 1'b0;
                            st_q <= ST_WBYTE;
                        end
                    end
                end
                ST_RBYTE: begin
                    if (scl_fall) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        oe_q <= !sh_q[6];
                    end
                    if (scl_rise) begin
                        sh_q <= sh_q;
                        if (cnt_q == `I2C_LAST_BIT) begin
                            st_q <= ST_MACK;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_fall && !ack_ph_q) begin
                        oe_q <= 1'b0;
                        ack_ph_q <= 1'b1;
                    end else if (scl_rise && ack_ph_q) begin
                        mack_q <= !sda;
                    end else if (scl_fall) begin
                        ack_ph_q <= 1'b0;
                        cnt_q <= '0;
                        if (mack_q) begin
                            sh_q <= rd_data;
                            oe_q <= !rd_data[7];
                            ptr_q <= ptr_q + 8'h01;
                            st_q <= ST_RBYTE;
                        end else begin
                            st_q <= ST_SKIP;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; the data line is only ever pulled low, never driven high
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign osc_req = st_q != ST_IDLE;
    assign rd_space = space_q;
    assign rd_addr = ptr_q;
endmodule : pmic_i2c_target

// ---- pmic_i2c_defs.svh ----
// Constants for the two-wire register target of the power controller.
// Assumes a 10 MHz system clock that samples both bus pins.
`ifndef PMIC_I2C_DEFS_SVH
`define PMIC_I2C_DEFS_SVH

`define I2C_MAIN_ADDR_RST 7'h5E
`define I2C_PROG_ADDR 7'h38
`define I2C_GCALL_ADDR 7'h00
`define I2C_TENBIT_PFX 5'h1E
`define I2C_TENBIT_POS 2
`define I2C_LAST_BIT 3'h7
`define WFIFO_DEPTH 4

`endif

// ---- pmic_i2c_pkg.sv ----
// Types shared by the two-wire register target.
// Assumes the constants header is compiled alongside.
package pmic_i2c_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WBYTE,
        ST_RBYTE,
        ST_ACK,
        ST_MACK,
        ST_SKIP
    } tgt_state_t;

    typedef struct packed {
        logic prog_space;
        logic [7:0] addr;
        logic [7:0] data;
    } wr_req_t;

endpackage : pmic_i2c_pkg

// ---- pmic_i2c_target_sva.sv ----
// Port checker for the two-wire register target.
// Bound onto pmic_i2c_target; bus pins idle high.
module pmic_i2c_target_sva
    import pmic_i2c_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic otp_done,
    input wire logic [6:0] main_addr_otp,
    input wire logic osc_req,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire wr_req_t wr_req,
    input wire logic rd_space,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_drive_frame:
        assert property (sda_oe |-> osc_req && !sda_o)
        else $error("drive outside transfer");
    a_wait_loaded:
        assert property (!otp_done |-> !osc_req && !sda_oe)
        else $error("active before load");
    a_start_low:
        assert property ($rose(osc_req) |-> !sda_i)
        else $error("start without data low");
    a_stop_high:
        assert property ($fell(osc_req) |-> sda_i && scl_i)
        else $error("end without stop");
    a_word_frame:
        assert property ($rose(wr_valid) |-> osc_req)
        else $error("word outside transfer");
    a_word_hold:
        assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_req))
        else $error("word dropped");
    a_ptr_step:
        assert property (wr_valid && wr_ready ##1 wr_valid |->
            wr_req.addr == $past(wr_req.addr) + 8'h01)
        else $error("pointer did not step");
    a_ptr_idle:
        assert property (!osc_req && !$past(osc_req) |-> $stable(rd_addr))
        else $error("pointer moved while idle");
endmodule : pmic_i2c_target_sva

bind pmic_i2c_target pmic_i2c_target_sva chk (.sys_clk(sys_clk),
    .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .otp_done(otp_done), .main_addr_otp(main_addr_otp),
    .osc_req(osc_req), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_req(wr_req), .rd_space(rd_space), .rd_addr(rd_addr),
    .rd_data(rd_data));

// ---- i2c_ctrl_model.sv ----
// Bus controller model: clock, start, stop and bytes.
// Assumes the bench resolves the pulled-up data wire.
module i2c_ctrl_model (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // Clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // 1 us bit: long low phase leaves room for the target's late answer
    task automatic bit_io(input logic b, output logic s);
        #300 sda_drv = b;
        #300 scl = 1'b1;
        #300 s = sda;
        #100 scl = 1'b0;
    endtask : bit_io
    task automatic start_c();
        if (scl === 1'b0) begin
            #600 sda_drv = 1'b1;
            #300 scl = 1'b1;
        end
        #300 sda_drv = 1'b0;
        #400 scl = 1'b0;
    endtask : start_c
    task automatic stop_c();
        #300 sda_drv = 1'b0;
        #300 scl = 1'b1;
        #300 sda_drv = 1'b1;
        #600;
    endtask : stop_c
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : send_byte
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(last, s);
    endtask : recv_byte
endmodule : i2c_ctrl_model

// ---- test_pmic_i2c_target.sv ----
// Self-checking bench for the two-wire register target.
// Assumes the controller model and port checker compile first.
module test_pmic_i2c_target;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic otp_done = 1'b0;
    logic wr_ready = 1'b0;
    logic [6:0] main_addr_otp = 7'h2A;
    logic [7:0] rd_data;
    logic sda_o, sda_oe, osc_req, wr_valid, rd_space;
    logic [7:0] rd_addr;
    pmic_i2c_pkg::wr_req_t wr_req;
    wire scl;
    wire ctl_sda;
    wire sda;
    integer n_mismatch = 0;
    integer n_tests = 0;
    assign sda = ~((sda_oe & ~sda_o) | ~ctl_sda);
    assign rd_data = rd_addr ^ 8'h5A;
    always #50 sys_clk = ~sys_clk;
    pmic_i2c_target dut (.sys_clk(sys_clk), .resetn(resetn), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .otp_done(otp_done),
        .main_addr_otp(main_addr_otp), .osc_req(osc_req),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req),
        .rd_space(rd_space), .rd_addr(rd_addr), .rd_data(rd_data));
    i2c_ctrl_model ctl (.scl(scl), .sda_drv(ctl_sda), .sda(sda));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [16:0] seen,
            input logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic cyc();
        @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic t_nack(input logic [6:0] a);
        logic ack;
        ctl.start_c();
        ctl.send_byte({a, 1'b0}, ack);
        check("refused ack", ack, 1'b0);
        ctl.stop_c();
        $display("done refuse %h", a);
    endtask : t_nack
    // Buffer fills while the bank stalls, then drains
    task automatic t_write();
        logic ack;
        ctl.start_c();
        ctl.send_byte({7'h2A, 1'b0}, ack);
        check("addr ack", ack, 1'b1);
        ctl.send_byte(8'h20, ack);
        for (int i = 0; i < 5; i++) begin
            ctl.send_byte(8'hA0 + i[7:0], ack);
            check("data ack", ack, i < 4);
        end
        check("in frame", osc_req, 1'b1);
        ctl.stop_c();
        check("idle", osc_req, 1'b0);
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 100 && wr_valid !== 1'b1; k++) cyc();
            if (wr_valid !== 1'b1) begin
                n_mismatch++;
                close_out();
            end
            check("word", wr_req, {1'b0, 8'h20 + i[7:0], 8'hA0 + i[7:0]});
            wr_ready = 1'b1;
            cyc();
            wr_ready = 1'b0;
            cyc();
        end
        cyc();
        check("empty", wr_valid, 1'b0);
        $display("done write");
    endtask : t_write
    task automatic t_read();
        logic ack;
        logic [7:0] b0, b1;
        ctl.start_c();
        ctl.send_byte({7'h38, 1'b0}, ack);
        check("prog ack", ack, 1'b1);
        ctl.send_byte(8'h10, ack);
        ctl.start_c();
        ctl.send_byte({7'h38, 1'b1}, ack);
        check("read ack", ack, 1'b1);
        ctl.recv_byte(1'b0, b0);
        ctl.recv_byte(1'b1, b1);
        check("space", rd_space, 1'b1);
        ctl.stop_c();
        check("byte0", b0, 8'h10 ^ 8'h5A);
        check("byte1", b1, 8'h11 ^ 8'h5A);
        $display("done read");
    endtask : t_read
    // Stored address set to a reserved code must still be refused
    task automatic t_reserved(input logic [6:0] a);
        resetn = 1'b0;
        otp_done = 1'b0;
        main_addr_otp = a;
        cyc();
        cyc();
        resetn = 1'b1;
        cyc();
        check("reset idle", {osc_req, sda_oe, wr_valid}, 3'b000);
        otp_done = 1'b1;
        cyc();
        t_nack(a);
    endtask : t_reserved
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'b1;
        cyc();
        t_nack(7'h5E);
        otp_done = 1'b1;
        cyc();
        t_nack(7'h5E);
        t_nack(7'h00);
        t_nack(7'h78);
        t_write();
        t_read();
        t_reserved(7'h00);
        t_reserved(7'h78);
        close_out();
    end
endmodule : test_pmic_i2c_target
